// File: rtl/trfd_defines.svh
`ifndef TRFD_DEFINES_SVH
`define TRFD_DEFINES_SVH
// clock and timing
`define TRFD_CLK_HZ        20000000
`define TRFD_MEAS_US       9600
`define TRFD_MEAS_CYC      ((`TRFD_MEAS_US * (`TRFD_CLK_HZ / 1000000)))
`define TRFD_AVG_N         16
`define TRFD_AVG_SHIFT     4
// register reset values and codes
`define TRFD_FAN_RST       8'h00
`define TRFD_FAN_FULL      8'hff
`define TRFD_TEMP_RST      8'h00
// configuration fields
`define TRFD_CFG_CH2_BIT   7
`define TRFD_CFG_RST       8'h00
`endif

// File: rtl/trfd_pkg.sv
`default_nettype none
package trfd_pkg;
   typedef enum logic [1:0] {
      CH_LOCAL,
      CH_REMOTE1,
      CH_REMOTE2
   } trfd_chan_e;
   typedef logic signed [7:0] trfd_temp_t;
endpackage : trfd_pkg
`default_nettype wire

// File: rtl/trfd_avg.sv
`timescale 1ns/1ps
`default_nettype none
`include "trfd_defines.svh"
module trfd_avg (
   // clock and reset
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   // raw samples
   input  wire logic              clr_i,
   input  wire logic              smp_vld_i,
   input  wire logic signed [7:0] smp_i,
   // averaged result
   output logic                   done_o,
   output logic signed [7:0]      avg_o
);
   logic signed [11:0] acc_q;
   logic        [3:0]  cnt_q;
   logic signed [11:0] acc_d;
   logic               last_w;

   assign acc_d  = acc_q + 12'(smp_i);
   assign last_w = smp_vld_i && (cnt_q == 4'(`TRFD_AVG_N - 1));

   // sum of sixteen samples shifted by four: two's complement mean
   always_ff @(posedge mclk_i) begin
      if (srst_i || clr_i) begin
         acc_q  <= 12'h000;
         cnt_q  <= 4'h0;
         done_o <= 1'b0;
         avg_o  <= `TRFD_TEMP_RST;
      end else begin
         done_o <= last_w;
         if (smp_vld_i) begin
            cnt_q <= cnt_q + 4'h1;
            acc_q <= last_w ? 12'h000 : acc_d;
         end
         if (last_w) begin
            avg_o <= acc_d[11:`TRFD_AVG_SHIFT];
         end
      end
   end
endmodule : trfd_avg
`default_nettype wire

// File: rtl/trfd_top.sv
// What this block does
// - on-chip sensor result is delivered as 8-bit two's complement
// - one lsb per degree; -128 is 80h, 0 is 00h, +127 is 7fh
// - second remote channel measures only when config bit 7 is set
// - first remote channel always measures, regardless of configuration
// - each remote result is the mean of 16 raw measurement cycles
// - a full remote measurement with averaging takes nominally 9.6 ms
// - remote results use the same 8-bit two's complement code
// - fan speed code is 8-bit unsigned driving the dac, zero minimum
// - reset loads fan speed code with 00h
// - fan speed pin high at power-up enters nand tree test mode
// - separate fan gating output switches fan on only while the speed code is nonzero
// - overtemp line driven low as input forces ffh and negates gating
// - each completed result is written into its readable value register
`timescale 1ns/1ps
`default_nettype none
`include "trfd_defines.svh"
module trfd_top #(
   parameter int unsigned MEAS_CYC = `TRFD_MEAS_CYC
) (
   // clock and reset
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   // converter front end
   input  wire logic              adc_vld_i,
   input  wire logic signed [7:0] adc_data_i,
   output logic [1:0]             adc_chan_o,
   output logic                   adc_start_o,
   // register access from the serial bus engine
   input  wire logic              cfg_we_i,
   input  wire logic [7:0]        cfg_wdata_i,
   input  wire logic              fan_we_i,
   input  wire logic [7:0]        fan_wdata_i,
   output logic [7:0]             cfg_o,
   output logic [7:0]             fan_speed_code_o,
   output logic signed [7:0]      local_temp_o,
   output logic signed [7:0]      remote1_temp_o,
   output logic signed [7:0]      remote2_temp_o,
   // shared pins
   input  wire logic              overtemp_line_i,
   input  wire logic              general_logic_input_i,
   output logic                   general_logic_o,
   // fan drive
   input  wire logic              fan_pin_i,
   output logic [7:0]             fan_speed_out_o,
   output logic                   fan_gate_o,
   output logic                   tree_test_entry_o
);
   localparam int unsigned SMP_CYC = MEAS_CYC / `TRFD_AVG_N;

   typedef enum logic [1:0] {
      ST_START,
      ST_WAIT
   } trfd_st_e;

   trfd_st_e              st_q;
   trfd_pkg::trfd_chan_e  chan_q;
   trfd_pkg::trfd_chan_e  chan_nxt_w;
   logic [23:0]           tmr_q;
   logic [23:0]           meas_q;
   logic                  boot_q;
   logic                  ch2_en_w;
   logic                  remote_w;
   logic                  force_w;
   logic                  smp_w;
   logic                  avg_clr_w;
   logic                  avg_done_w;
   logic signed [7:0]     avg_w;
   logic                  local_done_w;

   assign ch2_en_w = cfg_o[`TRFD_CFG_CH2_BIT];
   // remote one is always in the rotation
   assign chan_nxt_w = (chan_q == trfd_pkg::CH_LOCAL) ? trfd_pkg::CH_REMOTE1 :
                       (chan_q == trfd_pkg::CH_REMOTE1 && ch2_en_w) ?
                        trfd_pkg::CH_REMOTE2 : trfd_pkg::CH_LOCAL;
   assign remote_w     = (chan_q != trfd_pkg::CH_LOCAL);
   // sample timer paces 16 sub-samples over 9.6 ms
   assign smp_w        = (st_q == ST_WAIT) && remote_w && adc_vld_i &&
                         (tmr_q >= 24'(SMP_CYC - 1));
   assign avg_clr_w    = (st_q == ST_START);
   assign local_done_w = (st_q == ST_WAIT) && !remote_w && adc_vld_i;
   // overtemp line is an input only in default mode
   assign force_w      = !ch2_en_w && !overtemp_line_i;

   trfd_avg u_avg (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .clr_i     (avg_clr_w),
      .smp_vld_i (smp_w),
      .smp_i     (adc_data_i),
      .done_o    (avg_done_w),
      .avg_o     (avg_w)
   );

   // sequencer
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_q        <= ST_START;
         chan_q      <= trfd_pkg::CH_LOCAL;
         tmr_q       <= 24'h000000;
         adc_start_o <= 1'b0;
         adc_chan_o  <= 2'h0;
      end else begin
         adc_start_o <= 1'b0;
         case (st_q)
            ST_START: begin
               adc_start_o <= 1'b1;
               adc_chan_o  <= chan_q;
               tmr_q       <= 24'h000000;
               st_q        <= ST_WAIT;
            end
            ST_WAIT: begin
               if (tmr_q < 24'(SMP_CYC - 1)) begin
                  tmr_q <= tmr_q + 24'h000001;
               end
               if (smp_w) begin
                  tmr_q       <= 24'h000000;
                  adc_start_o <= 1'b1;
               end
               if (local_done_w || avg_done_w) begin
                  chan_q <= chan_nxt_w;
                  st_q   <= ST_START;
               end
            end
            default: st_q <= ST_START;
         endcase
      end
   end

   // conversion length counter, watched by the timing
   always_ff @(posedge mclk_i) begin
      if (srst_i || st_q == ST_START) begin
         meas_q <= 24'h000000;
      end else if (meas_q < 24'(MEAS_CYC)) begin
         meas_q <= meas_q + 24'h000001;
      end
   end

   // value registers, whole-byte update only at completion
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         local_temp_o   <= `TRFD_TEMP_RST;
         remote1_temp_o <= `TRFD_TEMP_RST;
         remote2_temp_o <= `TRFD_TEMP_RST;
      end else begin
         if (local_done_w) begin
            local_temp_o <= adc_data_i;
         end
         if (avg_done_w && chan_q == trfd_pkg::CH_REMOTE1) begin
            remote1_temp_o <= avg_w;
         end
         if (avg_done_w && chan_q == trfd_pkg::CH_REMOTE2) begin
            remote2_temp_o <= avg_w;
         end
      end
   end

   // configuration, fan code and fan outputs
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cfg_o             <= `TRFD_CFG_RST;
         fan_speed_code_o  <= `TRFD_FAN_RST;
         fan_speed_out_o   <= `TRFD_FAN_RST;
         fan_gate_o        <= 1'b0;
         general_logic_o   <= 1'b0;
         boot_q            <= 1'b1;
         tree_test_entry_o <= 1'b0;
      end else begin
         if (cfg_we_i) begin
            cfg_o <= cfg_wdata_i;
         end
         if (fan_we_i) begin
            fan_speed_code_o <= fan_wdata_i;
         end
         // forced full scale, otherwise the stored code
         fan_speed_out_o <= force_w ? `TRFD_FAN_FULL : fan_speed_code_o;
         // gate follows a nonzero code, negated while forced
         fan_gate_o      <= !force_w && (fan_speed_code_o != 8'h00);
         general_logic_o <= !ch2_en_w && general_logic_input_i;
         // pin sampled once after reset release
         boot_q <= 1'b0;
         if (boot_q) begin
            tree_test_entry_o <= fan_pin_i;
         end
      end
   end

   a_force_full: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      force_w |=> fan_speed_out_o == `TRFD_FAN_FULL && !fan_gate_o)
      else $error("fan not forced to full scale");
   a_fan_follow: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      !force_w |=> fan_speed_out_o == $past(fan_speed_code_o))
      else $error("fan output does not follow code");
   a_skip_ch2: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      !ch2_en_w |-> chan_nxt_w != trfd_pkg::CH_REMOTE2)
      else $error("disabled remote two scheduled");
   a_local_load: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      local_done_w |=> local_temp_o == $past(adc_data_i))
      else $error("local value not stored");
   a_atomic_hold: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      !(avg_done_w && chan_q == trfd_pkg::CH_REMOTE1)
      |=> $stable(remote1_temp_o))
      else $error("remote one changed mid conversion");
   a_rr_next: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      (local_done_w && chan_q == trfd_pkg::CH_LOCAL)
      |=> chan_q == trfd_pkg::CH_REMOTE1)
      else $error("remote one not after local");
   a_remote_avg: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      avg_done_w |-> remote_w)
      else $error("average completed on local channel");
   a_gate_zero: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      (fan_speed_code_o == 8'h00) |=> !fan_gate_o)
      else $error("gate on with zero code");
   a_gate_on: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      (!force_w && fan_speed_code_o != 8'h00) |=> fan_gate_o)
      else $error("gate off with nonzero code");
   a_gl_mode: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      ch2_en_w |=> !general_logic_o)
      else $error("logic input passed while remote two enabled");
   a_r2_load: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      (avg_done_w && chan_q == trfd_pkg::CH_REMOTE2)
      |=> remote2_temp_o == $past(avg_w))
      else $error("remote two value not stored");
   a_meas_time: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      avg_done_w |-> meas_q >= 24'(SMP_CYC * `TRFD_AVG_N))
      else $error("remote result before full measurement time");
endmodule : trfd_top
`default_nettype wire

// File: tb/trfd_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module trfd_front_model (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // request from the block
   input  wire logic        adc_start_i,
   input  wire logic [1:0]  adc_chan_i,
   // reported temperatures and a stray early valid
   input  wire logic [7:0]  loc_i,
   input  wire logic [7:0]  rem1_i,
   input  wire logic [7:0]  rem2_i,
   input  wire logic        early_i,
   // answer
   output logic             adc_vld_o,
   output logic [7:0]       adc_data_o
);
   int         wait_q;
   int         k_q;
   logic [1:0] ch_q;
   wire  [7:0] base = (ch_q == 2'h0) ? loc_i :
                      (ch_q == 2'h1) ? rem1_i : rem2_i;
   always @(posedge mclk_i) begin
      adc_vld_o <= 1'b0;
      adc_data_o <= ~adc_data_o;
      if (srst_i) begin
         wait_q <= 0;
         k_q <= 0;
         ch_q <= 2'h0;
         adc_data_o <= 8'h00;
      end else if (adc_start_i) begin
         wait_q <= 14;
         k_q <= (adc_chan_i == ch_q) ? k_q + 1 : 0;
         ch_q <= adc_chan_i;
      end else if (wait_q > 0) begin
         wait_q <= wait_q - 1;
         if (wait_q == 1) begin
            adc_vld_o <= 1'b1;
            // last of 16 raw samples is one lower: mean floors
            adc_data_o <= (ch_q != 2'h0 && k_q % 16 == 15) ?
                          base - 8'h01 : base;
         end else if (wait_q == 12 && early_i && ch_q != 2'h0) begin
            adc_vld_o <= 1'b1;
            adc_data_o <= 8'h80;
         end
      end
   end
endmodule : trfd_front_model
`default_nettype wire

// File: tb/temp_readout_fan_dac_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module temp_readout_fan_dac_ctrl_tb;
   logic mclk_i = 0, srst_i = 1, adc_vld_i, adc_start_o, cfg_we_i = 0;
   logic fan_we_i = 0, overtemp_line_i = 1, gl_in = 0, general_logic_o;
   logic fan_pin_i = 1, fan_gate_o, tree_test_entry_o, early = 0;
   logic [1:0] adc_chan_o;
   logic [7:0] cfg_wdata_i = 0, fan_wdata_i = 0, cfg_o, fan_speed_code_o;
   logic [7:0] fan_speed_out_o, loc = 8'h80, r1 = 8'h19, r2 = 8'h7f;
   trfd_pkg::trfd_temp_t adc_data_i, local_temp_o, remote1_temp_o;
   trfd_pkg::trfd_temp_t remote2_temp_o;
   int n_mismatch = 0, checks_done = 0;
   always #25 mclk_i = ~mclk_i;
   trfd_top #(.MEAS_CYC(160)) DUT (.mclk_i(mclk_i), .srst_i(srst_i),
      .adc_vld_i(adc_vld_i), .adc_data_i(adc_data_i),
      .adc_chan_o(adc_chan_o), .adc_start_o(adc_start_o),
      .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i), .fan_we_i(fan_we_i),
      .fan_wdata_i(fan_wdata_i), .cfg_o(cfg_o),
      .fan_speed_code_o(fan_speed_code_o), .local_temp_o(local_temp_o),
      .remote1_temp_o(remote1_temp_o), .remote2_temp_o(remote2_temp_o),
      .overtemp_line_i(overtemp_line_i), .general_logic_input_i(gl_in),
      .general_logic_o(general_logic_o), .fan_pin_i(fan_pin_i),
      .fan_speed_out_o(fan_speed_out_o), .fan_gate_o(fan_gate_o),
      .tree_test_entry_o(tree_test_entry_o));
   trfd_front_model model (.mclk_i(mclk_i), .srst_i(srst_i),
      .adc_start_i(adc_start_o), .adc_chan_i(adc_chan_o), .loc_i(loc),
      .rem1_i(r1), .rem2_i(r2), .early_i(early), .adc_vld_o(adc_vld_i),
      .adc_data_o(adc_data_i));
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic report_and_stop;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic fan, input logic [7:0] d);
      {fan_we_i, cfg_we_i} = fan ? 2'b10 : 2'b01;
      fan_wdata_i = d;
      cfg_wdata_i = d;
      @(negedge mclk_i);
      {fan_we_i, cfg_we_i} = 2'b00;
      repeat (2) @(negedge mclk_i);
   endtask : wr
   task automatic waitv(input int idx, input logic [7:0] e, input string nm);
      logic [7:0] g;
      for (int i = 0; i < 2000; i++) begin
         g = (idx == 0) ? local_temp_o :
             (idx == 1) ? remote1_temp_o : remote2_temp_o;
         if (g === e) break;
         @(negedge mclk_i);
      end
      chk(nm, e, g);
   endtask : waitv
   task automatic rst(input logic pin);
      srst_i = 1;
      fan_pin_i = pin;
      repeat (10) @(negedge mclk_i);
      srst_i = 0;
      @(negedge mclk_i);
      fan_pin_i = 0; // board keeps the fan pin low
      @(negedge mclk_i);
      chk("tree_test_entry_o", {7'h0, pin}, tree_test_entry_o);
      chk("fan_speed_code_o", 8'h00, fan_speed_code_o);
      chk("fan_speed_out_o", 8'h00, fan_speed_out_o);
   endtask : rst
   // remote two never started while disabled
   always @(posedge mclk_i) begin
      if (!srst_i && adc_start_o && !cfg_o[7]) begin
         chk("adc_chan_o[1]", 8'h0, {7'h0, adc_chan_o[1]});
      end
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      rst(1'b1);
      gl_in = 1;
      repeat (2) @(negedge mclk_i);
      chk("general_logic_o", 8'h1, {7'h0, general_logic_o});
      wr(1'b1, 8'h5a);
      chk("fan_speed_out_o", 8'h5a, fan_speed_out_o);
      chk("fan_gate_o", 8'h1, {7'h0, fan_gate_o});
      overtemp_line_i = 0;
      repeat (3) @(negedge mclk_i);
      chk("fan_speed_out_o", 8'hff, fan_speed_out_o);
      chk("fan_gate_o", 8'h0, {7'h0, fan_gate_o});
      chk("fan_speed_code_o", 8'h5a, fan_speed_code_o);
      overtemp_line_i = 1;
      waitv(0, 8'h80, "local_temp_o");
      waitv(1, 8'h18, "remote1_temp_o");
      chk("remote2_temp_o", 8'h00, remote2_temp_o);
      loc = 8'h7f;
      waitv(0, 8'h7f, "local_temp_o");
      early = 1;
      r1 = 8'h32;
      waitv(1, 8'h31, "remote1_temp_o");
      early = 0;
      wr(1'b0, 8'h80);
      chk("cfg_o", 8'h80, cfg_o);
      waitv(2, 8'h7e, "remote2_temp_o");
      overtemp_line_i = 0;
      repeat (3) @(negedge mclk_i);
      chk("fan_speed_out_o", 8'h5a, fan_speed_out_o);
      chk("general_logic_o", 8'h0, {7'h0, general_logic_o});
      overtemp_line_i = 1;
      wr(1'b1, 8'h00);
      chk("fan_gate_o", 8'h0, {7'h0, fan_gate_o});
      rst(1'b0);
      report_and_stop();
   end
endmodule : temp_readout_fan_dac_ctrl_tb
`default_nettype wire
